// ### src/frer_map.svh
// Register map, field positions, reset values and timing counts of the
// fixed reference enable/ready block.
// Assumes a 10 MHz core clock and a 32-bit classic Wishbone register bus.
`ifndef FRER_MAP_SVH
`define FRER_MAP_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define FRER_CTRL_OFS 8'h00
`define FRER_STAT_OFS 8'h04
`define FRER_MASK_OFS 8'h08
`define FRER_REQ_OFS 8'h0c

// ************************************************************
// Control register fields
// ************************************************************
`define FRER_EN_BIT 7
`define FRER_RDY_BIT 6
`define FRER_TEMP_INDICATOR_ENABLE_BIT 5
`define FRER_TEMP_INDICATOR_RANGE_BIT 4
`define FRER_GAIN_MSB 1
`define FRER_GAIN_LSB 0

// ************************************************************
// Interrupt status and mask fields
// ************************************************************
`define FRER_EV_RISE 0
`define FRER_EV_FALL 1

// ************************************************************
// Reset values
// ************************************************************
`define FRER_CTRL_RESET 8'h00
`define FRER_IRQ_RESET 2'h0

// ************************************************************
// Timing
// ************************************************************
`define FRER_CLK_PERIOD_NS 100
`define FRER_STAB_TIME_NS 25000
`define FRER_STAB_CYCLES 16'((`FRER_STAB_TIME_NS + `FRER_CLK_PERIOD_NS - 1) / `FRER_CLK_PERIOD_NS)

`endif

// ### src/frer_pkg.sv
// Types shared by the fixed reference enable/ready block.
// Assumes nothing beyond a SystemVerilog tool.
package frer_pkg;

  // Stabilization timer states, one-hot
  typedef enum logic [2:0] {
    ST_OFF = 3'h1,
    ST_SETTLE = 3'h2,
    ST_READY = 3'h4
  } frer_state_t;

  // ADC reference gain selections
  typedef enum logic [1:0] {
    GAIN_OFF = 2'h0,
    GAIN_X1 = 2'h1,
    GAIN_X2 = 2'h2,
    GAIN_X4 = 2'h3
  } frer_gain_t;

  // Brownout detector modes
  typedef enum logic [1:0] {
    BOR_OFF = 2'h0,
    BOR_SW = 2'h1,
    BOR_NSLEEP = 2'h2,
    BOR_ON = 2'h3
  } frer_bor_mode_t;

endpackage : frer_pkg

// ### src/frer_stab_if.sv
// Enable and ready pair between the control logic and the stabilization timer.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps

interface frer_stab_if;
  logic enable;
  logic ready;
  modport ctrl (output enable, input ready);
  modport timer (input enable, output ready);
endinterface : frer_stab_if

// ### src/frer_stab_timer.sv
// Stabilization timer: ready rises a fixed count after enable rises.
// Assumes enable comes from logic on clk_i; no synchroniser needed.
`timescale 1ns/1ps
`include "frer_map.svh"

module frer_stab_timer (
  input wire logic clk_i, // Core clock
  input wire logic rst_i, // Synchronous reset, active high
  frer_stab_if.timer stab // Enable in, ready out
);

  // ************************************************************
  // State and counter
  // ************************************************************
  frer_pkg::frer_state_t state_reg, state_next;
  logic [15:0] cnt_reg, cnt_next;

  // Next state; any drop of enable restarts the interval from zero
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      frer_pkg::ST_OFF: begin
        if (stab.enable) begin
          state_next = frer_pkg::ST_SETTLE;
          cnt_next = 16'h0001;
        end
      end
      frer_pkg::ST_SETTLE: begin
        if (!stab.enable) begin
          state_next = frer_pkg::ST_OFF;
          cnt_next = 16'h0000;
        end else if (cnt_reg == `FRER_STAB_CYCLES) begin
          state_next = frer_pkg::ST_READY;
        end else begin
          cnt_next = cnt_reg + 16'h0001;
        end
      end
      frer_pkg::ST_READY: begin
        if (!stab.enable) begin
          state_next = frer_pkg::ST_OFF;
          cnt_next = 16'h0000;
        end
      end
      default: begin
        state_next = frer_pkg::ST_OFF;
        cnt_next = 16'h0000;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= frer_pkg::ST_OFF;
      cnt_reg <= 16'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  assign stab.ready = (state_reg == frer_pkg::ST_READY);

  // ************************************************************
  // Checks
  // ************************************************************
  // Independent count of cycles enable has been held, saturating
  logic [16:0] on_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || !stab.enable) begin
      on_cnt <= 17'h00000;
    end else if (on_cnt <= {1'b0, `FRER_STAB_CYCLES}) begin
      on_cnt <= on_cnt + 17'h00001;
    end
  end

  ready_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    stab.ready == (on_cnt > {1'b0, `FRER_STAB_CYCLES}))
    else $error("ready does not match the stabilization count");

  settle_range_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (state_reg == frer_pkg::ST_SETTLE) |-> (cnt_reg >= 16'h0001 && cnt_reg <= `FRER_STAB_CYCLES))
    else $error("settle counter out of range");

endmodule : frer_stab_timer

// ### src/frer_top.sv
// Fixed reference enable/ready control: control register, request OR,
// stabilization tracking and a ready-change interrupt on classic Wishbone.
// Assumes request inputs come from logic on clk_i and the master follows
// classic single cycles.
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "frer_map.svh"

// Summary of operation
// - Ready stays low through the stabilization interval
// - Ready flag is read-only at bit six
// - Ready reads zero when off or settling
// - Bit five enables temperature indicator, resets zero
// - Brownout always-on, or sleep-off with fast start, forces on
// - Brownout software mode with fast start forces on
// - Regulated power-save select awake requests the reference
// - Bit seven software enable, resets to zero
// - Gain field selects four, two, one, or buffer off
module frer_top #(
  parameter bit REGULATED = 1'b1 // Part has the internal regulator
) (
  input wire logic clk_i, // Core clock, 10 MHz
  input wire logic rst_i, // Synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic oscillator_select_i, // External clock mode active
  input wire logic [1:0] brownout_mode_i, // Brownout detector mode
  input wire logic brownout_fast_start_i, // Brownout fast start
  input wire logic regulator_powersave_select_i, // Regulator power-save select
  input wire logic sleep_i, // Device in sleep
  output logic reference_on_o, // Effective reference enable
  output logic reference_ready_o, // Reference output usable
  output logic temp_indicator_enable_o, // Temperature indicator on
  output logic temp_indicator_range_o, // Temperature indicator range
  output logic [1:0] adc_reference_gain_o, // Gain field
  output logic [2:0] adc_gain_mult_o, // Gain factor, zero when buffer off
  output logic irq_o // Interrupt, level
);

  // ************************************************************
  // Helpers
  // ************************************************************
  // Gain code to multiplication factor; off turns the buffer off
  function automatic logic [2:0] gain_mult(input logic [1:0] g);
    logic [2:0] m;
    m = 3'h0;
    if (g == frer_pkg::GAIN_X4) begin
      m = 3'h4;
    end else if (g == frer_pkg::GAIN_X2) begin
      m = 3'h2;
    end else if (g == frer_pkg::GAIN_X1) begin
      m = 3'h1;
    end
    return m;
  endfunction : gain_mult

  // ************************************************************
  // Declarations
  // ************************************************************
  logic en_reg, en_next;
  logic temp_indicator_enable_reg, temp_indicator_enable_next;
  logic temp_indicator_range_reg, temp_indicator_range_next;
  logic [1:0] gain_reg, gain_next;
  logic [2:0] mult_reg, mult_next;
  logic ref_on_reg, ref_on_next;
  logic rdy_d_reg;
  logic [1:0] stat_reg, stat_next;
  logic [1:0] mask_reg, mask_next;
  logic irq_reg, irq_next;
  logic ack_reg, ack_next;
  logic [31:0] dat_reg, dat_next;
  logic access, wr_lo;
  logic osc_req, bor_req, ivr_req;
  logic ready;
  logic [1:0] ev_set, ev_clr;
  logic [7:0] ctrl_rd;

  frer_stab_if stab_bus ();

  frer_stab_timer u_timer (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .stab (stab_bus.timer)
  );

  // ************************************************************
  // Reference requests
  // ************************************************************
  // Internal units force the reference regardless of the software bit
  always_comb begin
    osc_req = oscillator_select_i;
    bor_req = (brownout_mode_i == frer_pkg::BOR_ON)
      || (brownout_mode_i == frer_pkg::BOR_NSLEEP && brownout_fast_start_i)
      || (brownout_mode_i == frer_pkg::BOR_SW && brownout_fast_start_i);
    ivr_req = REGULATED && regulator_powersave_select_i && !sleep_i;
    ref_on_next = en_reg | osc_req | bor_req | ivr_req;
  end

  // Timer sees the next enable so ready falls in the same edge as enable
  assign stab_bus.enable = ref_on_next;
  assign ready = stab_bus.ready;

  // ************************************************************
  // Register bus and register file
  // ************************************************************
  assign access = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_lo = access && wb_we_i && wb_sel_i[0];
  assign ctrl_rd = {en_reg, ready, temp_indicator_enable_reg, temp_indicator_range_reg, 2'h0, gain_reg};

  // Ready edges are the interrupt events
  assign ev_set = {rdy_d_reg && !ready, !rdy_d_reg && ready};

  // Next values; ack one cycle after the request, unmapped reads zero
  always_comb begin
    en_next = en_reg;
    temp_indicator_enable_next = temp_indicator_enable_reg;
    temp_indicator_range_next = temp_indicator_range_reg;
    gain_next = gain_reg;
    mask_next = mask_reg;
    ev_clr = 2'h0;
    dat_next = dat_reg;
    ack_next = access;
    if (access && !wb_we_i) begin
      dat_next = 32'h0000_0000;
    end
    if (wb_adr_i == `FRER_CTRL_OFS) begin
      if (wr_lo) begin
        en_next = wb_dat_i[`FRER_EN_BIT];
        temp_indicator_enable_next = wb_dat_i[`FRER_TEMP_INDICATOR_ENABLE_BIT];
        temp_indicator_range_next = wb_dat_i[`FRER_TEMP_INDICATOR_RANGE_BIT];
        gain_next = wb_dat_i[`FRER_GAIN_MSB:`FRER_GAIN_LSB];
      end
      if (access && !wb_we_i) begin
        dat_next = {24'h00_0000, ctrl_rd};
      end
    end else if (wb_adr_i == `FRER_STAT_OFS) begin
      if (wr_lo) begin
        ev_clr = wb_dat_i[1:0];
      end
      if (access && !wb_we_i) begin
        dat_next = {30'h0000_0000, stat_reg};
      end
    end else if (wb_adr_i == `FRER_MASK_OFS) begin
      if (wr_lo) begin
        mask_next = wb_dat_i[1:0];
      end
      if (access && !wb_we_i) begin
        dat_next = {30'h0000_0000, mask_reg};
      end
    end else if (wb_adr_i == `FRER_REQ_OFS) begin
      if (access && !wb_we_i) begin
        dat_next = {27'h000_0000, ref_on_reg, ivr_req, bor_req, osc_req, en_reg};
      end
    end
    // A new event wins over a clear in the same cycle
    stat_next = (stat_reg & ~ev_clr) | ev_set;
    irq_next = |(stat_next & mask_next);
    mult_next = gain_mult(gain_next);
  end

  // Registers only; every control bit clears on reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_reg <= 1'(`FRER_CTRL_RESET >> `FRER_EN_BIT);
      temp_indicator_enable_reg <= 1'(`FRER_CTRL_RESET >> `FRER_TEMP_INDICATOR_ENABLE_BIT);
      temp_indicator_range_reg <= 1'(`FRER_CTRL_RESET >> `FRER_TEMP_INDICATOR_RANGE_BIT);
      gain_reg <= 2'(`FRER_CTRL_RESET >> `FRER_GAIN_LSB);
      mult_reg <= 3'h0;
      ref_on_reg <= 1'b0;
      rdy_d_reg <= 1'b0;
      stat_reg <= `FRER_IRQ_RESET;
      mask_reg <= `FRER_IRQ_RESET;
      irq_reg <= 1'b0;
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      en_reg <= en_next;
      temp_indicator_enable_reg <= temp_indicator_enable_next;
      temp_indicator_range_reg <= temp_indicator_range_next;
      gain_reg <= gain_next;
      mult_reg <= mult_next;
      ref_on_reg <= ref_on_next;
      rdy_d_reg <= ready;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      ack_reg <= ack_next;
      dat_reg <= dat_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign reference_on_o = ref_on_reg;
  assign reference_ready_o = ready;
  assign temp_indicator_enable_o = temp_indicator_enable_reg;
  assign temp_indicator_range_o = temp_indicator_range_reg;
  assign adc_reference_gain_o = gain_reg;
  assign adc_gain_mult_o = mult_reg;
  assign irq_o = irq_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ready_wait_a: assert property ($rose(reference_on_o) |-> !reference_ready_o [*8])
    else $error("ready rose too soon after enable");

  ready_read_a: assert property (
    (wb_ack_o && !wb_we_i && wb_adr_i == `FRER_CTRL_OFS) |-> wb_dat_o[`FRER_RDY_BIT] == $past(reference_ready_o))
    else $error("read of ready bit is wrong");

  ready_off_a: assert property (!reference_on_o |-> !reference_ready_o)
    else $error("ready high while reference off");

  temp_reset_a: assert property ($past(rst_i) |-> !temp_indicator_enable_o)
    else $error("temperature enable not clear after reset");

  bor_force_a: assert property (
    (brownout_mode_i == 2'h3 || (brownout_mode_i == 2'h2 && brownout_fast_start_i)) |=> reference_on_o)
    else $error("brownout did not force the reference on");

  bor_sw_a: assert property ((brownout_mode_i == 2'h1 && brownout_fast_start_i) |=> reference_on_o)
    else $error("brownout software mode did not force reference");

  ivr_req_a: assert property (
    (REGULATED && regulator_powersave_select_i && !sleep_i) |=> reference_on_o)
    else $error("regulator did not request the reference");

  sw_enable_a: assert property (
    (wr_lo && wb_adr_i == `FRER_CTRL_OFS && wb_dat_i[7]) |-> ##2 reference_on_o)
    else $error("software enable did not turn reference on");

  gain_map_a: assert property (
    (adc_reference_gain_o == 2'h3 && adc_gain_mult_o == 3'h4)
    || (adc_reference_gain_o == 2'h2 && adc_gain_mult_o == 3'h2)
    || (adc_reference_gain_o == 2'h1 && adc_gain_mult_o == 3'h1)
    || (adc_reference_gain_o == 2'h0 && adc_gain_mult_o == 3'h0))
    else $error("gain factor does not match gain field");

  ref_or_a: assert property (!$past(rst_i) |-> reference_on_o ==
    ($past(en_reg) || $past(oscillator_select_i) || $past(bor_req) || $past(ivr_req)))
    else $error("reference enable is not the OR of requests");

  irq_level_a: assert property (!$past(rst_i) |-> irq_o == |(stat_reg & mask_reg))
    else $error("interrupt level does not follow status and mask");

  ready_rise_c: cover property ($rose(reference_ready_o));
  settle_abort_c: cover property (reference_on_o && !reference_ready_o ##1 !reference_on_o);
  irq_seen_c: cover property ($rose(irq_o));

endmodule : frer_top

// ### testbench/frer_top_tb.sv
// Self-checking bench for the fixed reference enable/ready block.
// Assumes frer_map.svh on the include path and a classic Wishbone slave.
`timescale 1ns/1ps
`include "frer_map.svh"

module frer_top_tb;
  // ************************************************************
  // Stimulus signals and counters
  // ************************************************************
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic osc_i = 1'b0;
  logic [1:0] bor_i = 2'h0;
  logic fs_i = 1'b0;
  logic rps_i = 1'b0;
  logic slp_i = 1'b0;
  logic reference_on_o;
  logic reference_ready_o;
  logic temp_indicator_enable_o;
  logic temp_indicator_range_o;
  logic [1:0] adc_reference_gain_o;
  logic [2:0] adc_gain_mult_o;
  logic irq_o;
  int error_cnt = 0;
  int checks_done = 0;
  localparam int STAB = int'(`FRER_STAB_CYCLES);

  frer_top #(.REGULATED(1'b1)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .oscillator_select_i(osc_i), .brownout_mode_i(bor_i),
    .brownout_fast_start_i(fs_i), .regulator_powersave_select_i(rps_i), .sleep_i(slp_i),
    .reference_on_o(reference_on_o), .reference_ready_o(reference_ready_o),
    .temp_indicator_enable_o(temp_indicator_enable_o), .temp_indicator_range_o(temp_indicator_range_o),
    .adc_reference_gain_o(adc_reference_gain_o), .adc_gain_mult_o(adc_gain_mult_o), .irq_o(irq_o)
  );

  // 100 ns clock
  initial begin
    forever #50 clk_i = ~clk_i;
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic timeout_hit(input string name);
    error_cnt++;
    $display("ERROR %s expected event seen timeout", name);
    complete_run();
  endtask : timeout_hit

  // Request held until ack is seen high at a rising edge; data taken and request released there
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= wd;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) timeout_hit("wb_ack_o");
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] unused;
    wb_xfer(1'b1, adr, d, unused);
  endtask : wr

  task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wb_xfer(1'b0, adr, 32'h0, rd);
    chk(name, exp, rd);
  endtask : rd_chk

  // Counts cycles from reference_on_o rising to reference_ready_o rising
  task automatic meas(input int exp);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (reference_on_o !== 1'b1 && n < 20);
    if (reference_on_o !== 1'b1) timeout_hit("reference_on_o");
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (reference_ready_o !== 1'b1 && n < 400);
    if (reference_ready_o !== 1'b1) timeout_hit("reference_ready_o");
    chk("ready delay", 32'(exp), 32'(n));
  endtask : meas

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic exp_on;
    logic [2:0] mult [4];
    mult = '{3'h0, 3'h1, 3'h2, 3'h4};
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("ctrl reset", `FRER_CTRL_OFS, 32'h0);
    rd_chk("stat reset", `FRER_STAT_OFS, 32'h0);
    rd_chk("mask reset", `FRER_MASK_OFS, 32'h0);
    rd_chk("unmapped", 8'h10, 32'h0);
    // Software enable with every writable bit set; ready bit write must be dropped
    wr(`FRER_CTRL_OFS, 32'hff);
    meas(STAB);
    chk("temp enable", 32'h1, 32'(temp_indicator_enable_o));
    chk("temp range", 32'h1, 32'(temp_indicator_range_o));
    chk("gain x4", 32'h4, 32'(adc_gain_mult_o));
    rd_chk("ctrl ready", `FRER_CTRL_OFS, 32'hf3);
    rd_chk("stat rise", `FRER_STAT_OFS, 32'h1);
    @(negedge clk_i);
    chk("irq masked", 32'h0, 32'(irq_o));
    wr(`FRER_MASK_OFS, 32'h3);
    @(negedge clk_i);
    chk("irq rise", 32'h1, 32'(irq_o));
    wr(`FRER_STAT_OFS, 32'h1);
    @(negedge clk_i);
    chk("irq cleared", 32'h0, 32'(irq_o));
    // Every gain code while the reference stays on
    for (int g = 0; g < 4; g++) begin
      wr(`FRER_CTRL_OFS, 32'h80 | 32'(g));
      @(negedge clk_i);
      chk("gain mult", 32'(mult[g]), 32'(adc_gain_mult_o));
      chk("gain field", 32'(g), 32'(adc_reference_gain_o));
    end
    // Disable: ready drops with the reference, fall event raises irq
    wr(`FRER_CTRL_OFS, 32'h0);
    @(negedge clk_i);
    chk("ready off", 32'h0, 32'(reference_ready_o));
    chk("reference off", 32'h0, 32'(reference_on_o));
    @(negedge clk_i);
    chk("irq fall", 32'h1, 32'(irq_o));
    rd_chk("stat fall", `FRER_STAT_OFS, 32'h2);
    wr(`FRER_STAT_OFS, 32'h3);
    wr(`FRER_MASK_OFS, 32'h0);
    wr(`FRER_CTRL_OFS, 32'h40);
    rd_chk("ready ro", `FRER_CTRL_OFS, 32'h0);
    // Every request combination; each held too briefly to become ready
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_i);
      {osc_i, bor_i, fs_i, rps_i, slp_i} <= 6'(i);
      exp_on = i[5] | (i[4:3] == 2'h3) | (i[4:3] != 2'h0 && i[2]) | (i[1] && !i[0]);
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      chk("request on", 32'(exp_on), 32'(reference_on_o));
      chk("settling", 32'h0, 32'(reference_ready_o));
      rd_chk("request status", `FRER_REQ_OFS, {27'h0, exp_on, i[1] && !i[0],
             (i[4:3] == 2'h3) || (i[4:3] != 2'h0 && i[2]), i[5], 1'b0});
      @(posedge clk_i);
      {osc_i, bor_i, fs_i, rps_i, slp_i} <= 6'h0;
      repeat (3) @(posedge clk_i);
    end
    // A one-cycle drop in mid-settle must restart the full count
    @(posedge clk_i);
    osc_i <= 1'b1;
    repeat (100) @(posedge clk_i);
    @(posedge clk_i);
    osc_i <= 1'b0;
    @(posedge clk_i);
    osc_i <= 1'b1;
    meas(STAB);
    // Reset in mid-run clears the writable bits
    wr(`FRER_CTRL_OFS, 32'h30);
    @(posedge clk_i);
    rst_i <= 1'b1;
    osc_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("ctrl rereset", `FRER_CTRL_OFS, 32'h0);
    complete_run();
  end
endmodule : frer_top_tb
